// [rtl/dzh_map.svh]
// Field positions, method codes and timing counts of the homing sequencer.
`ifndef DZH_MAP_SVH
`define DZH_MAP_SVH

// ----------------------------------------------------------------
// Control word and status word bit positions
// ----------------------------------------------------------------
`define DZH_CW_START_BIT 4
`define DZH_SW_TARGET_BIT 10
`define DZH_SW_HOMED_BIT 12

// ----------------------------------------------------------------
// Homing method codes, two's complement in eight bits
// ----------------------------------------------------------------
`define DZH_M_COUNT_F 8'hF9
`define DZH_M_COUNT_R 8'hD9
`define DZH_M_CRADLE_F 8'hF8
`define DZH_M_CRADLE_R 8'hD8
`define DZH_M_LASTZ_F 8'hF7
`define DZH_M_LASTZ_R 8'hD7
`define DZH_M_FRONT_F 8'hF6
`define DZH_M_FRONT_R 8'hD6
`define DZH_M_DOGLESS_F 8'hF5
`define DZH_M_DOGLESS_R 8'hD5

// ----------------------------------------------------------------
// Alarm number, reset values and dog sampling periods
// ----------------------------------------------------------------
`define DZH_ALARM_NUM 8'h5A
`define DZH_RST_WORD 16'h0000
`define DZH_RST_POS 32'h0000_0000
`define DZH_SMP_DIV_HOME 8'h10
`define DZH_SMP_DIV_CREEP 8'h01

`endif

// [rtl/dzh_pkg.sv]
// Types shared by the homing sequencer and its dog sampler.
package dzh_pkg;

  // Speed the servo loop is told to run at.
  typedef enum logic [1:0]
  {
    DZH_SPD_STOP = 2'b00,
    DZH_SPD_HOME = 2'b01,
    DZH_SPD_CREEP = 2'b10
  } dzh_speed_t;

  // Family of a homing method; the mirrored twin shares the family.
  typedef enum logic [2:0]
  {
    DZH_K_COUNT = 3'b000,
    DZH_K_CRADLE = 3'b001,
    DZH_K_LASTZ = 3'b010,
    DZH_K_FRONT = 3'b011,
    DZH_K_DOGLESS = 3'b100
  } dzh_kind_t;

  // Motion command handed to the servo loop.
  typedef struct packed
  {
    logic fwd;
    dzh_speed_t speed;
  } dzh_motion_t;

  // Sensor inputs seen by the sequencer.
  typedef struct packed
  {
    logic dog;
    logic z_phase;
    logic stroke_fwd;
    logic stroke_rev;
  } dzh_sense_t;

endpackage

// [rtl/dzh_dog_sampler.sv]
// Speed-dependent sampler of the proximity-dog input with edge pulses.
`timescale 1ns/1ps
`include "dzh_map.svh"
module dzh_dog_sampler
#(
  parameter logic [7:0] DIV_HOME = `DZH_SMP_DIV_HOME,
  parameter logic [7:0] DIV_CREEP = `DZH_SMP_DIV_CREEP
)
(
  input wire logic ref_clk, // System clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire dzh_pkg::dzh_speed_t speed, // Speed currently commanded.
  input wire logic dog_in, // Raw dog level.
  output logic dog_level, // Sampled dog level.
  output logic dog_front, // One-cycle pulse on a sampled rising dog.
  output logic dog_rear // One-cycle pulse on a sampled falling dog.
);
  import dzh_pkg::*;

  logic [7:0] smp_cnt;
  logic smp_en;
  logic [7:0] period;

  // ----------------------------------------------------------------
  // Sample enable
  // ----------------------------------------------------------------
  // The dog is read only on this enable, so a faster approach sees a coarser front edge.
  always_comb
  begin
    case (speed)
      DZH_SPD_HOME: period = DIV_HOME;
      DZH_SPD_CREEP: period = DIV_CREEP;
      default: period = 8'h01;
    endcase
  end

  assign smp_en = (smp_cnt == 8'h00);

  // Free-running divider reloaded from the current period.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      smp_cnt <= 8'h00;
    else if (smp_en)
      smp_cnt <= period - 8'h01;
    else
      smp_cnt <= smp_cnt - 8'h01;
  end

  // Sampled level and edge pulses.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dog_level <= 1'b0;
      dog_front <= 1'b0;
      dog_rear <= 1'b0;
    end
    else
    begin
      dog_front <= smp_en && dog_in && !dog_level;
      dog_rear <= smp_en && !dog_in && dog_level;
      if (smp_en)
        dog_level <= dog_in;
    end
  end

endmodule // dzh_dog_sampler

// [rtl/dzh_homing.sv]
// Dog and Z-phase homing sequencer with mirrored-direction methods.
`timescale 1ns/1ps
`include "dzh_map.svh"

// How it works
// - Methods -39 to -43 run the -7 to -11 sequences in opposite direction.
// - Count type latches the dog front end from a sampled dog input.
// - Dog sampling is coarser at homing speed, so the error grows with speed.
// - Count type alarms if post-dog distance ends before creep speed is reached.
// - In I/O mode completion loads the home position value as current position.
// - Home shift distance comes from two parameter halves.
// - Post-dog travel distance comes from two parameter halves.
// - Last Z-phase type alarms if the dog rear is met before stopping.
// - Starting on the dog, all but the dogless types first retract before the dog, then home.
module dzh_homing
(
  input wire logic ref_clk, // 40 MHz system clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic [15:0] ctrl_word, // Control word from the motion controller.
  input wire logic [7:0] homing_method, // Selected method code, signed.
  input wire logic io_mode, // High when the amplifier runs in I/O mode.
  input wire dzh_pkg::dzh_sense_t sense, // Dog, Z-phase and stroke end levels.
  input wire logic pos_step, // One pulse per encoder unit of travel.
  input wire logic at_creep, // Speed has come down to creep speed.
  input wire logic motor_stopped, // Motor is at standstill.
  input wire logic [15:0] home_shift_param_a, // Home shift distance, low half.
  input wire logic [15:0] home_shift_param_b, // Home shift distance, high half.
  input wire logic [15:0] post_switch_travel_a, // Travel after dog, low half.
  input wire logic [15:0] post_switch_travel_b, // Travel after dog, high half.
  input wire logic [15:0] home_position_value_a, // Home position data, low half.
  input wire logic [15:0] home_position_value_b, // Home position data, high half.
  output dzh_pkg::dzh_motion_t motion, // Direction and speed for the servo loop.
  output logic [15:0] status_word, // Status word to the motion controller.
  output logic homing_incomplete_alarm, // Homing alarm, held until next start.
  output logic [7:0] alarm_code, // Alarm number while the alarm stands.
  output logic home_pos_load, // One-cycle pulse: load home_pos_data.
  output logic [31:0] home_pos_data // Value to load as current position.
);
  import dzh_pkg::*;

  typedef enum logic [3:0]
  {
    ST_IDLE = 4'b0000,
    ST_RETRACT = 4'b0001,
    ST_SEEK = 4'b0010,
    ST_ESCAPE = 4'b0011,
    ST_POSTDOG = 4'b0100,
    ST_STOPDOG = 4'b0101,
    ST_CRADLE_BACK = 4'b0110,
    ST_CRADLE_FWD = 4'b0111,
    ST_Z_BACK = 4'b1000,
    ST_Z_WAIT = 4'b1001,
    ST_SHIFT = 4'b1010,
    ST_SETTLE = 4'b1011,
    ST_FAULT = 4'b1100
  } dzh_state_t;

  dzh_state_t state;
  dzh_state_t next_state;
  dzh_kind_t kind;
  dzh_kind_t next_kind;
  logic home_fwd;
  logic next_home_fwd;
  logic method_ok;
  logic start_prev;
  logic start_edge;
  logic [31:0] travel;
  logic [31:0] shift_dist;
  logic [31:0] post_dist;
  logic [31:0] home_value;
  logic dog_level;
  logic dog_front;
  logic dog_rear;
  logic stroke_ahead;
  logic escape_seen;
  dzh_motion_t next_motion;

  // ----------------------------------------------------------------
  // Configuration words and method decode
  // ----------------------------------------------------------------
  assign shift_dist = {home_shift_param_b, home_shift_param_a};
  assign post_dist = {post_switch_travel_b, post_switch_travel_a};
  assign home_value = {home_position_value_b, home_position_value_a};
  assign start_edge = ctrl_word[`DZH_CW_START_BIT] && !start_prev;
  assign stroke_ahead = motion.fwd ? sense.stroke_fwd : sense.stroke_rev;

  // Each mirrored twin maps to the same family with the home direction reversed.
  always_comb
  begin
    method_ok = 1'b1;
    next_home_fwd = 1'b1;
    case (homing_method)
      `DZH_M_COUNT_F: next_kind = DZH_K_COUNT;
      `DZH_M_CRADLE_F: next_kind = DZH_K_CRADLE;
      `DZH_M_LASTZ_F: next_kind = DZH_K_LASTZ;
      `DZH_M_FRONT_F: next_kind = DZH_K_FRONT;
      `DZH_M_DOGLESS_F: next_kind = DZH_K_DOGLESS;
      `DZH_M_COUNT_R:
      begin
        next_kind = DZH_K_COUNT;
        next_home_fwd = 1'b0;
      end
      `DZH_M_CRADLE_R:
      begin
        next_kind = DZH_K_CRADLE;
        next_home_fwd = 1'b0;
      end
      `DZH_M_LASTZ_R:
      begin
        next_kind = DZH_K_LASTZ;
        next_home_fwd = 1'b0;
      end
      `DZH_M_FRONT_R:
      begin
        next_kind = DZH_K_FRONT;
        next_home_fwd = 1'b0;
      end
      `DZH_M_DOGLESS_R:
      begin
        next_kind = DZH_K_DOGLESS;
        next_home_fwd = 1'b0;
      end
      default:
      begin
        next_kind = DZH_K_COUNT;
        method_ok = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Dog sampling
  // ----------------------------------------------------------------
  // The sample period follows the commanded speed.
  dzh_dog_sampler u_dog
  (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .speed(motion.speed),
    .dog_in(sense.dog),
    .dog_level(dog_level),
    .dog_front(dog_front),
    .dog_rear(dog_rear)
  );

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  // Next state; a new start is only taken when idle, settled or faulted.
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE, ST_FAULT, ST_SETTLE:
        if (start_edge && method_ok)
          next_state = (sense.dog && next_kind != DZH_K_DOGLESS) ? ST_RETRACT : ST_SEEK;
      ST_RETRACT:
        if (dog_rear || !dog_level)
          next_state = ST_SEEK;
      ST_SEEK:
        if (kind == DZH_K_DOGLESS && sense.z_phase)
          next_state = ST_SHIFT;
        else if (kind != DZH_K_DOGLESS && dog_front)
        begin
          case (kind)
            DZH_K_COUNT: next_state = ST_POSTDOG;
            DZH_K_CRADLE: next_state = ST_CRADLE_BACK;
            DZH_K_LASTZ: next_state = ST_STOPDOG;
            default: next_state = ST_SHIFT;
          endcase
        end
        else if (stroke_ahead)
          next_state = ST_ESCAPE;
      ST_ESCAPE:
        if (kind == DZH_K_DOGLESS || (escape_seen && !dog_level))
          next_state = ST_SEEK;
      ST_POSTDOG:
        if (travel >= post_dist)
          next_state = at_creep ? ST_SHIFT : ST_FAULT;
      ST_STOPDOG:
        if (dog_rear)
          next_state = ST_FAULT;
        else if (motor_stopped)
          next_state = ST_Z_BACK;
      ST_CRADLE_BACK:
        if (dog_rear)
          next_state = ST_CRADLE_FWD;
      ST_CRADLE_FWD:
        if (dog_front)
          next_state = ST_SHIFT;
      ST_Z_BACK:
        if (!dog_level)
          next_state = ST_Z_WAIT;
      ST_Z_WAIT:
        if (sense.z_phase)
          next_state = ST_SHIFT;
      ST_SHIFT:
        if (travel >= shift_dist)
          next_state = ST_SETTLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // Motion per state; away-from-home travel uses the mirrored direction.
  always_comb
  begin
    next_motion.fwd = home_fwd;
    next_motion.speed = DZH_SPD_HOME;
    case (next_state)
      ST_RETRACT, ST_ESCAPE:
        next_motion.fwd = (state == ST_IDLE || state == ST_FAULT || state == ST_SETTLE) ? !next_home_fwd : !home_fwd;
      ST_SEEK:
        if (state == ST_IDLE || state == ST_FAULT || state == ST_SETTLE)
          next_motion.fwd = next_home_fwd;
      ST_POSTDOG, ST_CRADLE_FWD, ST_Z_WAIT, ST_SHIFT: next_motion.speed = DZH_SPD_CREEP;
      ST_CRADLE_BACK, ST_Z_BACK:
      begin
        next_motion.fwd = !home_fwd;
        next_motion.speed = DZH_SPD_CREEP;
      end
      ST_STOPDOG, ST_IDLE, ST_SETTLE, ST_FAULT: next_motion.speed = DZH_SPD_STOP;
      default: next_motion.speed = DZH_SPD_STOP;
    endcase
  end

  // State, method latch and motion command registers.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= ST_IDLE;
      kind <= DZH_K_COUNT;
      home_fwd <= 1'b1;
      start_prev <= 1'b0;
      motion <= '{fwd: 1'b1, speed: DZH_SPD_STOP};
    end
    else
    begin
      state <= next_state;
      start_prev <= ctrl_word[`DZH_CW_START_BIT];
      motion <= next_motion;
      if (start_edge && method_ok && (state == ST_IDLE || state == ST_FAULT || state == ST_SETTLE))
      begin
        kind <= next_kind;
        home_fwd <= next_home_fwd;
      end
    end
  end

  // Distance travelled since the current state was entered.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      travel <= `DZH_RST_POS;
    else if (next_state != state)
      travel <= `DZH_RST_POS;
    else if (pos_step)
      travel <= travel + 32'h0000_0001;
  end

  // Escape from a stroke end, in all but the dogless type, must pass fully back across the dog before seeking again.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      escape_seen <= 1'b0;
    else if (state != ST_ESCAPE)
      escape_seen <= 1'b0;
    else if (dog_level)
      escape_seen <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Status, alarm and home position load
  // ----------------------------------------------------------------
  // Status bits fall on a new start and rise once the shift has ended.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      status_word <= `DZH_RST_WORD;
    else if (next_state == ST_SETTLE && state == ST_SHIFT)
    begin
      status_word[`DZH_SW_HOMED_BIT] <= 1'b1;
      status_word[`DZH_SW_TARGET_BIT] <= 1'b1;
    end
    else if (next_state != state && next_state != ST_SETTLE)
      status_word <= `DZH_RST_WORD;
  end

  // The alarm holds until the controller starts homing again.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      homing_incomplete_alarm <= 1'b0;
      alarm_code <= 8'h00;
    end
    else if (next_state == ST_FAULT && state != ST_FAULT)
    begin
      homing_incomplete_alarm <= 1'b1;
      alarm_code <= `DZH_ALARM_NUM;
    end
    else if (state == ST_FAULT && next_state != ST_FAULT)
    begin
      homing_incomplete_alarm <= 1'b0;
      alarm_code <= 8'h00;
    end
  end

  // Completion in I/O mode loads the configured home value; other modes keep position.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      home_pos_load <= 1'b0;
      home_pos_data <= `DZH_RST_POS;
    end
    else
    begin
      home_pos_load <= io_mode && state == ST_SHIFT && next_state == ST_SETTLE;
      if (io_mode && state == ST_SHIFT && next_state == ST_SETTLE)
        home_pos_data <= home_value;
    end
  end

endmodule // dzh_homing

// [bench/dzh_homing_asserts.sv]
// Concurrent checks on the ports of the homing sequencer.
`timescale 1ns/1ps
module dzh_homing_asserts
  import dzh_pkg::*;
(
  input wire logic ref_clk, // Clock.
  input wire logic rst_b, // Reset, active low.
  input wire logic [15:0] ctrl_word, // Control word.
  input wire logic [7:0] homing_method, // Method code.
  input wire logic io_mode, // I/O mode level.
  input wire logic [15:0] home_position_value_a, // Home data, low half.
  input wire logic [15:0] home_position_value_b, // Home data, high half.
  input wire dzh_pkg::dzh_motion_t motion, // Motion command.
  input wire logic [15:0] status_word, // Status word.
  input wire logic homing_incomplete_alarm, // Alarm level.
  input wire logic [7:0] alarm_code, // Alarm number.
  input wire logic home_pos_load, // Load pulse.
  input wire logic [31:0] home_pos_data // Loaded value.
);
  // ----------------------------------------------------------------
  // Sequences and properties
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Restarts are only judged from a settled or faulted state, since a stop inside last-Z looks like idle.
  sequence s_start;
    $rose(ctrl_word[4]) && motion.speed == DZH_SPD_STOP && (status_word[12] || homing_incomplete_alarm)
      && homing_method[3:0] inside {[4'h5:4'h9]} && (homing_method[7:4] == 4'hF || homing_method[7:4] == 4'hD);
  endsequence
  sequence s_done;
    $rose(status_word[12]);
  endsequence

  chk_start_moves: assert property (s_start |=> motion.speed == DZH_SPD_HOME && status_word == 16'h0000
    && !homing_incomplete_alarm) else $error("start did not begin homing");
  chk_done_after_creep: assert property (s_done |-> $past(motion.speed) == DZH_SPD_CREEP)
    else $error("completion without creep shift");
  chk_load_cause: assert property (s_done and $past(io_mode) |-> home_pos_load)
    else $error("completion in io mode without load");
  chk_load_done: assert property (home_pos_load |-> $past(io_mode) && status_word == 16'h1400
    && home_pos_data == {$past(home_position_value_b), $past(home_position_value_a)}) else $error("bad load");
  chk_load_pulse: assert property (home_pos_load |=> !home_pos_load)
    else $error("load pulse too long");
  chk_alarm_code: assert property (alarm_code == (homing_incomplete_alarm ? 8'h5A : 8'h00))
    else $error("alarm code mismatch");
  chk_alarm_stops: assert property (homing_incomplete_alarm |-> motion.speed == DZH_SPD_STOP
    && status_word == 16'h0000) else $error("alarm while moving");
  chk_status_form: assert property (status_word == 16'h0000 || status_word == 16'h1400)
    else $error("status bits not paired");
  chk_done_stop: assert property (status_word[12] |-> motion.speed == DZH_SPD_STOP)
    else $error("homed while moving");
endmodule // dzh_homing_asserts

bind dzh_homing dzh_homing_asserts i_dzh_homing_asserts (.ref_clk, .rst_b, .ctrl_word, .homing_method, .io_mode,
  .home_position_value_a, .home_position_value_b, .motion, .status_word, .homing_incomplete_alarm, .alarm_code,
  .home_pos_load, .home_pos_data);

// [bench/dzh_plant.sv]
// Behavioural motor, dog, Z-phase and stroke model on the far side of the sequencer.
`timescale 1ns/1ps
module dzh_plant
  import dzh_pkg::*;
(
  input wire logic ref_clk, // Clock.
  input wire logic rst_b, // Reloads the position, active low.
  input wire logic lag, // Motor never slows nor stops when high.
  input wire logic signed [15:0] start_pos, // Position loaded in reset.
  input wire dzh_pkg::dzh_motion_t motion, // Command from the sequencer.
  output dzh_pkg::dzh_sense_t sense, // Sensor levels.
  output logic pos_step, // One pulse per unit.
  output logic at_creep, // Creep reached.
  output logic motor_stopped, // Standstill.
  output logic signed [15:0] pos // Current position.
);
  // ----------------------------------------------------------------
  // Motion
  // ----------------------------------------------------------------
  logic tick;
  logic ran;
  logic moving;
  logic signed [15:0] mag;
  // With lag the motor coasts on once it has run and never reports creep, which is how the alarm cases are provoked.
  assign moving = motion.speed != DZH_SPD_STOP || (lag && ran);
  assign at_creep = !lag && motion.speed == DZH_SPD_CREEP;
  assign motor_stopped = !moving;
  assign mag = pos < 0 ? -pos : pos;
  // Dog sits symmetric about zero so both method twins meet one.
  assign sense = {mag >= 16'sd40 && mag <= 16'sd60, pos[2:0] == 3'd4, pos >= 16'sd200, pos <= -16'sd200};

  // One unit of travel every second cycle.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pos <= start_pos;
      tick <= 1'b0;
      ran <= 1'b0;
      pos_step <= 1'b0;
    end
    else
    begin
      tick <= ~tick;
      ran <= ran | (motion.speed != DZH_SPD_STOP);
      pos_step <= moving && tick;
      if (moving && tick)
        pos <= motion.fwd ? pos + 16'sd1 : pos - 16'sd1;
    end
  end
endmodule // dzh_plant

// [bench/testbench.sv]
// Self-checking bench for the homing sequencer.
`timescale 1ns/1ps
module testbench;
  import dzh_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic prst_b = 1'b0;
  logic [15:0] ctrl_word = 16'h0000;
  logic [7:0] homing_method = 8'hF5;
  logic io_mode = 1'b1;
  logic lag = 1'b0;
  logic signed [15:0] start_pos = 16'h0000;
  logic [15:0] shift_a = 16'h0003;
  logic [15:0] hpv_a = 16'h0000;
  dzh_sense_t sense;
  dzh_motion_t motion;
  logic pos_step, at_creep, motor_stopped, alarm, home_pos_load, d;
  logic [15:0] status_word;
  logic [7:0] alarm_code;
  logic [31:0] home_pos_data;
  logic signed [15:0] pos;
  logic [9:0] dirs;
  logic [7:0] meth [10] = '{8'hF9, 8'hD9, 8'hF8, 8'hD8, 8'hF7, 8'hD7, 8'hF6, 8'hD6, 8'hF5, 8'hD5};
  int fails = 0;
  int checked = 0;
  int loads = 0;
  int cyc = 0;

  always #12.5 ref_clk = ~ref_clk;

  // Distances are kept short but long enough to decelerate.
  dzh_homing i_dzh_homing (.ref_clk(ref_clk), .rst_b(rst_b), .ctrl_word(ctrl_word), .homing_method(homing_method),
    .io_mode(io_mode), .sense(sense), .pos_step(pos_step), .at_creep(at_creep), .motor_stopped(motor_stopped),
    .home_shift_param_a(shift_a), .home_shift_param_b(16'h0000), .post_switch_travel_a(16'h0005),
    .post_switch_travel_b(16'h0000), .home_position_value_a(hpv_a), .home_position_value_b(16'hA5A5),
    .motion(motion), .status_word(status_word), .homing_incomplete_alarm(alarm), .alarm_code(alarm_code),
    .home_pos_load(home_pos_load), .home_pos_data(home_pos_data));
  dzh_plant i_dzh_plant (.ref_clk(ref_clk), .rst_b(prst_b), .lag(lag), .start_pos(start_pos), .motion(motion),
    .sense(sense), .pos_step(pos_step), .at_creep(at_creep), .motor_stopped(motor_stopped), .pos(pos));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task test_done;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Places the motor, pulses the start bit and waits for completion or alarm.
  task run(input logic [7:0] m, input logic signed [15:0] sp, input logic lg);
    int n;
    @(negedge ref_clk);
    homing_method = m;
    start_pos = sp;
    lag = lg;
    prst_b = 1'b0;
    @(negedge ref_clk);
    prst_b = 1'b1;
    loads = 0;
    ctrl_word = 16'h0010;
    repeat (2) @(negedge ref_clk);
    d = motion.fwd;
    ctrl_word = 16'h0000;
    n = 0;
    while (status_word[12] !== 1'b1 && alarm !== 1'b1 && n < 4000)
    begin
      @(negedge ref_clk);
      n = n + 1;
    end
    // One more cycle lets the load counter see the pulse registered with the status bits.
    @(negedge ref_clk);
    check(32'(n < 4000), 32'h0000_0001);
  endtask

  // Counts load pulses; a stuck pulse shows as a count above one.
  always @(posedge ref_clk)
    if (home_pos_load === 1'b1)
      loads <= loads + 1;

  // Cuts a hang short well above the expected run length.
  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      fails = fails + 1;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(negedge ref_clk);
    rst_b = 1'b1;
    prst_b = 1'b1;
    // Every method once, home data changed per run.
    for (int i = 0; i < 10; i++)
    begin
      hpv_a = 16'(i);
      run(meth[i], 16'h0000, 1'b0);
      dirs[i] = d;
      check(32'(status_word), 32'h0000_1400);
      check(home_pos_data, {16'hA5A5, 16'(i)});
      check(32'(loads), 32'h0000_0001);
      check(32'(alarm), 32'h0000_0000);
    end
    for (int k = 0; k < 5; k++)
      check(32'(dirs[2 * k + 1]), 32'(!dirs[2 * k]));
    // Start inside the dog retracts first.
    run(8'hF6, 16'h0032, 1'b0);
    check(32'(d), 32'(!dirs[6]));
    check(32'(status_word), 32'h0000_1400);
    // Motor that never slows or stops provokes both alarms, then a clean restart clears it.
    run(8'hF9, 16'h0000, 1'b1);
    check({7'h00, alarm, alarm_code, status_word}, 32'h015A_0000);
    run(8'hF7, 16'h0000, 1'b1);
    check({7'h00, alarm, alarm_code, status_word}, 32'h015A_0000);
    run(8'hF7, 16'h0000, 1'b0);
    check({7'h00, alarm, alarm_code, status_word}, 32'h0000_1400);
    // Dogless from half a turn off the Z mark; the final place shows the shift, no load outside I/O mode.
    // The plant covers one more unit in the cycle in which the registered stop command takes effect.
    io_mode = 1'b0;
    for (int s = 0; s < 6; s += 5)
    begin
      shift_a = 16'(s);
      run(8'hF5, 16'h0000, 1'b0);
      check(32'(pos < 0 ? -pos : pos), 32'(5 + s));
      check(32'(loads), 32'h0000_0000);
    end
    // A code outside the table is ignored.
    @(negedge ref_clk);
    homing_method = 8'hF4;
    ctrl_word = 16'h0010;
    repeat (4) @(negedge ref_clk);
    check(32'(motion.speed), 32'h0000_0000);
    ctrl_word = 16'h0000;
    test_done();
  end
endmodule // testbench
